// *** rtl/adcr_bank.sv ***
// adcr_bank: register bank of a four-channel converter controller: clock
// divider, completion/compare flags with interrupt, byte holding latch,
// trim word, compare threshold and formatted channel results.
// assumes one AHB-Lite master, synchronous converter status on conv_in, and
// that software loads the factory trim word itself.
//
// Behaviour
// (R01) converter clock enable every 4,8,...,512 bus clocks per 3-bit code
// (R02) a channel's flag in bits 3:0 sets when its conversion finishes
// (R03) in compare mode the flag sets only when the compare condition holds
// (R04) a channel's flag clears when its interrupt vector executes
// (R05) writing one to a flag clears it; zero leaves it alone
// (R06) reading a low byte of a 16-bit pair copies its high byte to latch
// (R07) the holding latch is an ordinary read/write register too
// (R08) 12-bit trim word: low byte bits 7:0, high byte bits 3:0 hold 11:8
// (R09) software copies factory trim into the trim registers; hardware never does
// (R10) left-adjusted 12-bit: high byte bits 11:4, low byte 3:0 then zeros
// (R11) right-adjusted 12-bit: high byte bits 11:8, low byte bits 7:0
// (R12) right-adjusted high nibble is sign in differential use, else zero
// (R13) 8-bit: low byte result, high byte sign-filled when signed, else zero
// (R14) 16-bit threshold, high byte msbs, two's complement when signed
// (R15) threshold low register holds the eight low threshold bits
// (R16) threshold low write parks in latch; high write updates both bytes
// (R17) reserved flag and trim-high bits read zero, writes ignored
//
// The AHB-Lite slave port was chosen for this implementation.
`default_nettype none

module adcr_bank (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire adcr_pkg::adcr_conv_t conv_in,
    output logic                    adc_clk_en,
    output logic                    irq
);

    typedef enum logic [1:0] {
        ADCR_BUS_IDLE,
        ADCR_BUS_WRITE,
        ADCR_BUS_READ_WAIT,
        ADCR_BUS_READ_DONE
    } adcr_bus_t;

    typedef struct packed {
        adcr_bus_t        phase;
        logic [5:0]       idx;
        logic [8:0]       div_cnt;
        logic [2:0]       div_code;
        logic             clk_en;
        logic [3:0]       flags;
        logic [3:0]       mask;
        logic [7:0]       latch;
        logic [11:0]      trim;
        logic [15:0]      thr;
        logic [3:0][11:0] res;
        logic [31:0]      rdata;
    } adcr_state_t;

    // every field resets to a constant, so the async branch holds no logic
    localparam adcr_state_t RST_STATE = '{
        phase:    ADCR_BUS_IDLE,
        idx:      6'h00,
        div_cnt:  9'h000,
        div_code: adcr_pkg::RST_DIV,
        clk_en:   1'b0,
        flags:    4'h0,
        mask:     4'h0,
        latch:    adcr_pkg::RST_BYTE,
        trim:     adcr_pkg::RST_TRIM,
        thr:      adcr_pkg::RST_THR,
        res:      '0,
        rdata:    32'h0000_0000
    };

    adcr_state_t s;
    adcr_state_t n;

    // terminal count of the divider for a given code
    function automatic logic [8:0] div_limit(input logic [2:0] code);
        logic [9:0] f;
        f = (adcr_pkg::DIV_BASE << code) - 10'h001;
        return f[8:0];
    endfunction

    // present a raw result as {high byte, low byte}
    function automatic logic [15:0] fmt_result(
        input logic [11:0]              raw,
        input adcr_pkg::adcr_res_mode_t mode,
        input logic                     sext
    );
        logic [15:0] v;
        v = 16'h0000;
        case (mode)
            // (R10) left adjusted
            adcr_pkg::ADCR_RES_12_LEFT:
                v = {raw[11:4], raw[3:0], 4'h0};
            // (R13) 8-bit sign fill
            adcr_pkg::ADCR_RES_8:
                v = {(sext ? {8{raw[7]}} : 8'h00), raw[7:0]};
            // (R11) right adjusted
            default:
                // (R12) sign nibble
                v = {(sext ? {4{raw[11]}} : 4'h0), raw};
        endcase
        return v;
    endfunction

    // compare a fresh result against the threshold
    function automatic logic cmp_hit(
        input logic [15:0] val,
        input logic [15:0] thr,
        input logic        signed_mode,
        input logic        above
    );
        logic gt;
        // (R14) two's complement threshold
        gt = signed_mode ? ($signed(val) > $signed(thr)) : (val > thr);
        return above ? gt : !gt;
    endfunction

    // channel number of a result register index
    function automatic logic [1:0] res_chan(input logic [5:0] idx);
        logic [5:0] off;
        off = idx - adcr_pkg::IDX_RES_BASE;
        return off[2:1];
    endfunction

    function automatic logic is_res(input logic [5:0] idx);
        return (idx >= adcr_pkg::IDX_RES_BASE) && (idx <= adcr_pkg::IDX_RES_LAST);
    endfunction

    logic [3:0]  set_flags;
    logic [3:0]  clr_flags;
    logic        acc;
    logic [15:0] shown;
    logic [15:0] cmp_val;
    logic        disp_sext;
    logic [1:0]  rd_ch;

    always_comb
    begin
        n         = s;
        n.clk_en  = 1'b0;
        set_flags = 4'h0;
        clr_flags = 4'h0;
        shown     = 16'h0000;
        cmp_val   = 16'h0000;
        disp_sext = 1'b0;
        rd_ch     = 2'h0;
        // hsize is not decoded: every register is one aligned word
        acc       = hsel && htrans[1] && hready;

        // (R01) converter clock divider
        // >= rather than ==: a code lowered below the running count fires next
        // cycle instead of wrapping through all 512 states
        if (s.div_cnt >= div_limit(s.div_code))
        begin
            n.div_cnt = 9'h000;
            n.clk_en  = 1'b1;
        end
        else
        begin
            n.div_cnt = s.div_cnt + 9'h001;
        end

        for (int ch = 0; ch < adcr_pkg::NUM_CH; ch++)
        begin
            if (conv_in.done[ch])
            begin
                n.res[ch] = conv_in.result[ch];
                // compare always on the right-aligned value, never the left layout
                cmp_val = fmt_result(conv_in.result[ch],
                    (conv_in.res_mode == adcr_pkg::ADCR_RES_8) ?
                        adcr_pkg::ADCR_RES_8 : adcr_pkg::ADCR_RES_12_RIGHT,
                    conv_in.conv_signed);
                // (R02) completion sets flag
                // (R03) compare mode gating
                set_flags[ch] = !conv_in.cmp_en[ch] ||
                    cmp_hit(cmp_val, s.thr, conv_in.conv_signed, conv_in.cmp_above[ch]);
            end
        end

        // (R04) vector execution clears
        clr_flags = conv_in.vector_ack;

        // data phase of the accepted transfer
        case (s.phase)
            ADCR_BUS_WRITE:
            begin
                if (s.idx == adcr_pkg::IDX_DIVIDER)
                begin
                    n.div_code = hwdata[adcr_pkg::DIV_W-1:0];
                end
                else if (s.idx == adcr_pkg::IDX_FLAGS)
                begin
                    // (R05) write one to clear
                    clr_flags = clr_flags | hwdata[3:0];
                end
                else if (s.idx == adcr_pkg::IDX_LATCH)
                begin
                    // (R07) latch written directly
                    n.latch = hwdata[7:0];
                end
                else if (s.idx == adcr_pkg::IDX_IRQ_MASK)
                begin
                    n.mask = hwdata[3:0];
                end
                else if (s.idx == adcr_pkg::IDX_TRIM_LO)
                begin
                    // (R08) trim low byte
                    n.trim[7:0] = hwdata[7:0];
                end
                else if (s.idx == adcr_pkg::IDX_TRIM_HI)
                begin
                    // (R17) upper nibble dropped
                    n.trim[11:8] = hwdata[adcr_pkg::TRIM_HI_W-1:0];
                end
                else if (s.idx == adcr_pkg::IDX_THR_LO)
                begin
                    // (R16) low byte parked
                    n.latch = hwdata[7:0];
                end
                else if (s.idx == adcr_pkg::IDX_THR_HI)
                begin
                    // (R16) both bytes together
                    // a high write with no low write first commits whatever the latch holds
                    n.thr = {hwdata[7:0], s.latch};
                end
            end
            ADCR_BUS_READ_WAIT:
            begin
                n.phase = ADCR_BUS_READ_DONE;
                // unmapped indices fall through every branch and read zero
                n.rdata = 32'h0000_0000;
                if (s.idx == adcr_pkg::IDX_DIVIDER)
                begin
                    n.rdata[adcr_pkg::DIV_W-1:0] = s.div_code;
                end
                else if (s.idx == adcr_pkg::IDX_FLAGS)
                begin
                    // (R17) reserved bits zero
                    n.rdata[3:0] = s.flags;
                end
                else if (s.idx == adcr_pkg::IDX_LATCH)
                begin
                    // (R07) latch readable
                    n.rdata[7:0] = s.latch;
                end
                else if (s.idx == adcr_pkg::IDX_IRQ_MASK)
                begin
                    n.rdata[3:0] = s.mask;
                end
                else if (s.idx == adcr_pkg::IDX_TRIM_LO)
                begin
                    n.rdata[7:0] = s.trim[7:0];
                end
                else if (s.idx == adcr_pkg::IDX_TRIM_HI)
                begin
                    // (R08) trim high nibble
                    n.rdata[adcr_pkg::TRIM_HI_W-1:0] = s.trim[11:8];
                end
                else if (s.idx == adcr_pkg::IDX_THR_LO)
                begin
                    // (R15) threshold low byte
                    n.rdata[7:0] = s.thr[7:0];
                    // (R06) high byte to latch
                    n.latch = s.thr[15:8];
                end
                else if (s.idx == adcr_pkg::IDX_THR_HI)
                begin
                    // high half of a pair reads the latch, so a low-then-high
                    // sequence sees one consistent snapshot
                    n.rdata[7:0] = s.latch;
                end
                else if (is_res(s.idx))
                begin
                    rd_ch     = res_chan(s.idx);
                    disp_sext = (conv_in.res_mode == adcr_pkg::ADCR_RES_8) ?
                        conv_in.conv_signed : conv_in.diff[rd_ch];
                    shown = fmt_result(s.res[rd_ch], conv_in.res_mode, disp_sext);
                    if (s.idx[0] == 1'b0)
                    begin
                        n.rdata[7:0] = shown[7:0];
                        // (R06) high byte to latch
                        n.latch = shown[15:8];
                    end
                    else
                    begin
                        n.rdata[7:0] = s.latch;
                    end
                end
            end
            // idle or read done: no data phase side effects
            default:
            begin
            end
        endcase

        // set wins over any clear in the same cycle
        n.flags = (s.flags & ~clr_flags) | set_flags;

        if (s.phase != ADCR_BUS_READ_WAIT)
        begin
            if (acc)
            begin
                n.idx   = haddr[7:2];
                n.phase = hwrite ? ADCR_BUS_WRITE : ADCR_BUS_READ_WAIT;
            end
            else
            begin
                n.phase = ADCR_BUS_IDLE;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= RST_STATE;
        end
        else
        begin
            s <= n;
        end
    end

    // one wait state on reads gives the read side effects a registered source
    assign hreadyout  = (s.phase != ADCR_BUS_READ_WAIT);
    assign hresp      = 1'b0;
    assign hrdata     = s.rdata;
    assign adc_clk_en = s.clk_en;
    // level output: drops in the same cycle as the last unmasked flag or mask bit clears
    assign irq        = |(s.flags & s.mask);

endmodule

`default_nettype wire

// *** rtl/adcr_pkg.sv ***
// adcr_pkg: register indices, field layouts, reset values and carrier types
// for the converter result register bank.
// assumes a 32-bit AHB-Lite bus; byte address of a register is four times its index.
`default_nettype none

package adcr_pkg;

    // register indices (byte address = 4 * index)
    localparam logic [5:0] IDX_DIVIDER   = 6'h04;
    localparam logic [5:0] IDX_FLAGS     = 6'h06;
    localparam logic [5:0] IDX_LATCH     = 6'h07;
    localparam logic [5:0] IDX_IRQ_MASK  = 6'h08;
    localparam logic [5:0] IDX_TRIM_LO   = 6'h0c;
    localparam logic [5:0] IDX_TRIM_HI   = 6'h0d;
    localparam logic [5:0] IDX_THR_LO    = 6'h18;
    localparam logic [5:0] IDX_THR_HI    = 6'h19;
    // channel n: low byte at IDX_RES_BASE + 2n, high byte one above
    localparam logic [5:0] IDX_RES_BASE  = 6'h20;
    localparam logic [5:0] IDX_RES_LAST  = 6'h27;

    localparam int unsigned NUM_CH       = 4;
    localparam int unsigned RES_W        = 12;

    // field layouts
    localparam int unsigned DIV_W        = 3;
    localparam int unsigned DIV_CNT_W    = 9;
    localparam logic [9:0]  DIV_BASE     = 10'h004;
    localparam int unsigned TRIM_HI_W    = 4;

    // reset values
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_THR      = 16'h0000;
    localparam logic [11:0] RST_TRIM     = 12'h000;
    localparam logic [2:0]  RST_DIV      = 3'h0;

    // result presentation, driven by the converter's control registers
    typedef enum logic [1:0] {
        ADCR_RES_12_RIGHT = 2'h0,
        ADCR_RES_RSVD     = 2'h1,
        ADCR_RES_8        = 2'h2,
        ADCR_RES_12_LEFT  = 2'h3
    } adcr_res_mode_t;

    // everything the converter core and interrupt controller hand to the bank
    typedef struct packed {
        logic [3:0]        done;        // conversion complete, one-cycle pulse per channel
        logic [3:0]        vector_ack;  // channel interrupt vector executed, pulse
        logic [3:0]        cmp_en;      // channel runs in compare mode
        logic [3:0]        cmp_above;   // 1: hit when result above threshold, 0: at or below
        logic [3:0]        diff;        // channel in differential operation
        logic              conv_signed; // signed conversion mode
        adcr_res_mode_t    res_mode;
        logic [3:0][11:0]  result;      // raw result, valid with done
    } adcr_conv_t;

endpackage

`default_nettype wire

// *** sim/adcr_bank_bench.sv ***
// adcr_bank_bench: self-checking bench for the converter register bank
// assumes one AHB-Lite master here and the converter model beside the bank
`default_nettype none

module adcr_bank_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 hclk    = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel    = 1'b0;
    logic [31:0]          haddr   = 32'h0;
    logic [1:0]           htrans  = 2'h0;
    logic                 hwrite  = 1'b0;
    logic [2:0]           hsize   = 3'h2;
    logic [31:0]          hwdata  = 32'h0;
    logic                 hreadyout;
    logic                 hresp;
    logic [31:0]          hrdata;
    logic                 adc_clk_en;
    logic                 irq;
    adcr_pkg::adcr_conv_t conv;
    int                   n_fail   = 0;
    int                   compares = 0;
    int                   cyc      = 0;
    logic [31:0]          rd;

    always #2.5 hclk = ~hclk;

    adcr_conv_model CONV (.hclk(hclk), .conv(conv));

    adcr_bank DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_in(conv),
        .adc_clk_en(adc_clk_en), .irq(irq));

    task automatic summarize;
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, idx, 2'h0};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    task automatic pair(input logic [7:0] lo, input logic [7:0] hi);
        rdchk(adcr_pkg::IDX_RES_BASE + 6'h6, lo);
        rdchk(adcr_pkg::IDX_LATCH, hi);
        rdchk(adcr_pkg::IDX_RES_BASE + 6'h7, hi);
    endtask

    task automatic t_reset;
        logic [5:0] idx [10];
        idx = '{6'h04, 6'h06, 6'h07, 6'h08, 6'h0c, 6'h0d, 6'h18, 6'h19, 6'h20, 6'h21};
        foreach (idx[i])
            rdchk(idx[i], 8'h00);
    endtask

    task automatic t_div;
        int n;
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, adcr_pkg::IDX_DIVIDER, {5'h1f, 3'(c)});
            rdchk(adcr_pkg::IDX_DIVIDER, {5'h00, 3'(c)});
            @(posedge hclk iff adc_clk_en);
            n = 0;
            do
            begin
                @(posedge hclk);
                n++;
            end
            while (adc_clk_en !== 1'b1 && n < 600);
            chk(32'(n), 32'(4 << c));
        end
    endtask

    task automatic t_flags;
        bus(1'b1, adcr_pkg::IDX_IRQ_MASK, 8'h0f);
        CONV.finish(2'd2, 12'h123);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h04);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, adcr_pkg::IDX_FLAGS, 8'hfb);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h04);
        bus(1'b1, adcr_pkg::IDX_FLAGS, 8'h04);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h00);
        chk({31'h0, irq}, 32'h0);
        for (int c = 0; c < 4; c++)
            CONV.finish(2'(c), 12'h000);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h0f);
        CONV.ack(4'hf);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h00);
        bus(1'b1, adcr_pkg::IDX_IRQ_MASK, 8'h0d);
        CONV.finish(2'd1, 12'h000);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h02);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, adcr_pkg::IDX_IRQ_MASK, 8'h0f);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h02);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, adcr_pkg::IDX_FLAGS, 8'hff);
    endtask

    task automatic t_cmp;
        bus(1'b1, adcr_pkg::IDX_THR_LO, 8'h10);
        rdchk(adcr_pkg::IDX_LATCH, 8'h10);
        bus(1'b1, adcr_pkg::IDX_THR_HI, 8'h01);
        rdchk(adcr_pkg::IDX_THR_LO, 8'h10);
        rdchk(adcr_pkg::IDX_LATCH, 8'h01);
        rdchk(adcr_pkg::IDX_THR_HI, 8'h01);
        CONV.cfg(4'h1, 4'h1, 4'h0, 1'b0, adcr_pkg::ADCR_RES_12_RIGHT);
        CONV.finish(2'd0, 12'h110);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h00);
        CONV.finish(2'd0, 12'h111);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h01);
        bus(1'b1, adcr_pkg::IDX_FLAGS, 8'h01);
        CONV.cfg(4'h1, 4'h0, 4'h0, 1'b0, adcr_pkg::ADCR_RES_12_RIGHT);
        CONV.finish(2'd0, 12'h111);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h00);
        CONV.finish(2'd0, 12'h110);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h01);
        bus(1'b1, adcr_pkg::IDX_FLAGS, 8'h01);
        bus(1'b1, adcr_pkg::IDX_THR_LO, 8'hf0);
        bus(1'b1, adcr_pkg::IDX_THR_HI, 8'hff);
        CONV.cfg(4'h1, 4'h1, 4'h0, 1'b0, adcr_pkg::ADCR_RES_12_RIGHT);
        CONV.finish(2'd0, 12'h010);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h00);
        CONV.cfg(4'h1, 4'h1, 4'h0, 1'b1, adcr_pkg::ADCR_RES_12_RIGHT);
        CONV.finish(2'd0, 12'h010);
        rdchk(adcr_pkg::IDX_FLAGS, 8'h01);
        bus(1'b1, adcr_pkg::IDX_FLAGS, 8'h01);
    endtask

    task automatic t_res;
        bus(1'b1, adcr_pkg::IDX_LATCH, 8'h5a);
        rdchk(adcr_pkg::IDX_LATCH, 8'h5a);
        CONV.cfg(4'h0, 4'h0, 4'h8, 1'b0, adcr_pkg::ADCR_RES_12_RIGHT);
        CONV.finish(2'd3, 12'habc);
        pair(8'hbc, 8'hfa);
        CONV.cfg(4'h0, 4'h0, 4'h0, 1'b0, adcr_pkg::ADCR_RES_12_RIGHT);
        pair(8'hbc, 8'h0a);
        CONV.cfg(4'h0, 4'h0, 4'h0, 1'b0, adcr_pkg::ADCR_RES_12_LEFT);
        pair(8'hc0, 8'hab);
        CONV.cfg(4'h0, 4'h0, 4'h0, 1'b1, adcr_pkg::ADCR_RES_8);
        pair(8'hbc, 8'hff);
        CONV.cfg(4'h0, 4'h0, 4'h0, 1'b0, adcr_pkg::ADCR_RES_8);
        pair(8'hbc, 8'h00);
    endtask

    task automatic t_trim;
        bus(1'b1, adcr_pkg::IDX_TRIM_LO, 8'h34);
        bus(1'b1, adcr_pkg::IDX_TRIM_HI, 8'hf7);
        rdchk(adcr_pkg::IDX_TRIM_LO, 8'h34);
        rdchk(adcr_pkg::IDX_TRIM_HI, 8'h07);
        bus(1'b1, 6'h3f, 8'hff);
        rdchk(6'h3f, 8'h00);
    endtask

    // run takes about 2300 cycles; the ceiling leaves room for slow answers
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_div();
        t_flags();
        t_cmp();
        t_res();
        t_trim();
        summarize();
    end
endmodule

bind adcr_bank adcr_monitor MON (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .conv_in(conv_in), .adc_clk_en(adc_clk_en), .irq(irq));

`default_nettype wire

// *** sim/adcr_conv_model.sv ***
// adcr_conv_model: converter core and interrupt controller as seen by the bank
// assumes the bench calls its tasks; every change follows a rising edge
`default_nettype none

module adcr_conv_model (
    input  wire logic                hclk,
    output var adcr_pkg::adcr_conv_t conv
);
    timeunit 1ns;
    timeprecision 100ps;

    initial conv = '0;

    task automatic cfg(input logic [3:0] cmp, input logic [3:0] above, input logic [3:0] diff,
                       input logic sgn, input adcr_pkg::adcr_res_mode_t mode);
        @(posedge hclk);
        conv.cmp_en      <= cmp;
        conv.cmp_above   <= above;
        conv.diff        <= diff;
        conv.conv_signed <= sgn;
        conv.res_mode    <= mode;
    endtask

    task automatic finish(input logic [1:0] ch, input logic [11:0] val);
        @(posedge hclk);
        conv.done[ch]   <= 1'b1;
        conv.result[ch] <= val;
        @(posedge hclk);
        conv.done[ch]   <= 1'b0;
        // stale result shown inverted so a late capture is caught
        conv.result[ch] <= ~val;
    endtask

    task automatic ack(input logic [3:0] ch);
        @(posedge hclk);
        conv.vector_ack <= ch;
        @(posedge hclk);
        conv.vector_ack <= 4'h0;
    endtask
endmodule

`default_nettype wire

// *** sim/adcr_monitor.sv ***
// adcr_monitor: bus timing, divider pulse and interrupt checks on the bank's ports
// assumes hready is tied to hreadyout and one AHB-Lite master
`default_nettype none

module adcr_monitor (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic                 hready,
    input  wire logic                 hreadyout,
    input  wire logic                 hresp,
    input  wire logic [31:0]          hrdata,
    input  wire adcr_pkg::adcr_conv_t conv_in,
    input  wire logic                 adc_clk_en,
    input  wire logic                 irq
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic       take;
    logic       wr_dp;
    logic       rd_dp;
    logic [5:0] rd_idx;

    assign take = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_dp  <= 1'b0;
            rd_dp  <= 1'b0;
            rd_idx <= 6'h00;
        end
        else
        begin
            wr_dp  <= take && hwrite;
            rd_dp  <= take ? !hwrite : (rd_dp && !hreadyout);
            rd_idx <= take ? haddr[7:2] : rd_idx;
        end
    end

    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    read_wait_a: assert property (take && !hwrite |=> s_rd_wait)
        else $error("read without exactly one wait state");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response other than okay");
    div_gap_a: assert property (adc_clk_en |=> !adc_clk_en [*3])
        else $error("converter clock pulses closer than four cycles");
    div_period_a: assert property (adc_clk_en |-> ##[4:1000] adc_clk_en)
        else $error("converter clock pulse missing");
    vec_clear_a: assert property (&conv_in.vector_ack && !(|conv_in.done) |=> !irq)
        else $error("interrupt stays after all vectors executed");
    irq_cause_a: assert property ($rose(irq) |-> $past(|conv_in.done) || $past(wr_dp))
        else $error("interrupt rose without conversion or write");
    rsvd_zero_a: assert property (rd_dp && hreadyout &&
        (rd_idx == adcr_pkg::IDX_FLAGS || rd_idx == adcr_pkg::IDX_TRIM_HI)
        |-> hrdata[31:4] == 28'h0)
        else $error("reserved bits read nonzero");
endmodule

`default_nettype wire
